// *** core/fers_pkg.sv ***
// constants shared by the erase result status block
package fers_pkg;

   // register offsets on the plain register port (byte addresses)
   localparam logic [7:0] FERS_OFS_RESULT   = 8'h00;
   localparam logic [7:0] FERS_OFS_CTRL     = 8'h04;
   localparam logic [7:0] FERS_OFS_STATUS   = 8'h08;
   localparam logic [7:0] FERS_OFS_IRQ_STAT = 8'h0c;
   localparam logic [7:0] FERS_OFS_IRQ_MASK = 8'h10;

   // erase result word field positions
   localparam int FERS_BIT_PASS_FAIL  = 0;
   localparam int FERS_BIT_BLOCK_SEL  = 3;
   localparam int FERS_BIT_KEY_ERR    = 4;
   localparam int FERS_BIT_EXEC_ERR   = 5;
   localparam int FERS_BIT_PROTECT    = 6;

   // control, status and interrupt field positions
   localparam int FERS_BIT_CTRL_START = 0;
   localparam int FERS_BIT_STAT_BUSY  = 0;
   localparam int FERS_BIT_IRQ_DONE   = 0;
   localparam int FERS_BIT_IRQ_FAIL   = 1;

   // reset values
   localparam logic [7:0] FERS_RST_RESULT   = 8'h00;
   localparam logic [1:0] FERS_RST_IRQ_MASK = 2'h0;

   // expected key and the array-select code that picks the user boot array
   localparam logic [7:0] FERS_KEY_GOOD     = 8'h5a;
   localparam logic [7:0] FERS_SEL_USR_BOOT = 8'haa;

   // erase watchdog: time in microseconds and its cycle count at 40 MHz
   localparam int FERS_CLK_MHZ          = 40;
   localparam int FERS_ERASE_TIMEOUT_US = 10000;
   localparam int FERS_ERASE_TIMEOUT_CYC = FERS_ERASE_TIMEOUT_US * FERS_CLK_MHZ;

   // sequencer states
   typedef enum logic [1:0] {
      FERS_IDLE  = 2'b00,
      FERS_CHECK = 2'b01,
      FERS_RUN   = 2'b10,
      FERS_WAIT  = 2'b11
   } fers_state_t;

endpackage : fers_pkg

// *** core/fers_top.sv ***
// erase result status sequencer with register port and interrupt
`timescale 1ns/1ps

module fers_top
   import fers_pkg::*;
#(
   parameter int BLK_W          = 4,
   parameter int NUM_BLOCKS     = 8,
   parameter int TIMEOUT_CYCLES = FERS_ERASE_TIMEOUT_CYC
) (
   input  wire logic             sys_clk_i,
   input  wire logic             reset_i,
   input  wire logic [7:0]       addr_i,
   input  wire logic [7:0]       wr_data_i,
   input  wire logic             wr_i,
   input  wire logic             rd_i,
   input  wire logic [7:0]       flash_key_reg_i,
   input  wire logic [7:0]       array_select_reg_i,
   input  wire logic [BLK_W-1:0] block_num_i,
   input  wire logic             flash_error_state_i,
   input  wire logic             settings_changed_i,
   input  wire logic             erase_done_i,
   input  wire logic             erase_fail_i,
   output logic [7:0]            rd_data_o,
   output logic                  erase_start_o,
   output logic [BLK_W-1:0]      erase_block_o,
   output logic                  irq_o
);

   // refuse shapes the block register and the watchdog counter cannot serve
   initial begin
      if (BLK_W < 1 || BLK_W > 16)
         $error("fers_top: BLK_W out of range");
      if (NUM_BLOCKS < 1 || NUM_BLOCKS > (1 << BLK_W))
         $error("fers_top: NUM_BLOCKS does not fit BLK_W");
      if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > 16777215)
         $error("fers_top: TIMEOUT_CYCLES out of range");
   end

   localparam logic [BLK_W-1:0] LAST_BLOCK = BLK_W'(NUM_BLOCKS - 1);
   localparam logic [23:0]      TMO_LAST   = 24'(TIMEOUT_CYCLES - 1);

   // register map on the plain port, byte addresses
   //    result word  read only, holds the last completed attempt
   //    control      write only, bit 0 launches an erase while idle
   //    status       read only, bit 0 high while a sequence runs
   //    irq status   read clears, bit 0 done, bit 1 failed
   //    irq mask     read write, same layout as irq status
   // read data come back in the cycle after the strobe, then fall to zero,
   // so a late sampler reads zero rather than a stale word

   // sequence timing, one line per clock edge after the start write
   //    edge 1  check cycle: protect, key and select sampled, block number as latched at the start write
   //    edge 2  launch pulse if all checks passed, else result published
   //    edge 3  first wait cycle, completion looked at from here on
   //    edge n  completion seen, result and events on the next edge
   // a check failure never pulses the launch, so the array stays untouched

   // limitations worth knowing
   //    a start written while busy is dropped, software must poll busy
   //    the watchdog turns a silent array engine into an execution error
   //    the result word keeps its value until the next attempt completes

   // builds the result word; unused positions are forced to zero
   function automatic logic [7:0] fers_pack(input logic prot, input logic exec,
                                            input logic key, input logic blk);
      logic [7:0] w;
      w = 8'h00;
      w[FERS_BIT_PROTECT]   = prot;
      w[FERS_BIT_EXEC_ERR]  = exec;
      w[FERS_BIT_KEY_ERR]   = key;
      w[FERS_BIT_BLOCK_SEL] = blk;
      w[FERS_BIT_PASS_FAIL] = prot | exec | key | blk;
      return w;
   endfunction : fers_pack

   // address compare used by both read and write decode
   function automatic logic fers_hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction : fers_hit

   // register state
   fers_state_t      state_q, state_d;
   logic [7:0]       result_q, result_d;
   logic             prot_q, prot_d;
   logic             key_q, key_d;
   logic             blk_q, blk_d;
   logic             chg_q, chg_d;
   logic [23:0]      tmo_q, tmo_d;
   logic             start_q, start_d;
   logic [BLK_W-1:0] eblk_q, eblk_d;
   logic [1:0]       istat_q, istat_d;
   logic [1:0]       imask_q, imask_d;
   logic [7:0]       rdata_q, rdata_d;
   logic             irq_q, irq_d;

   // decoded strobes
   logic start_req;
   logic rd_istat;
   logic ev_done;
   logic ev_fail;

   assign start_req = wr_i && fers_hit(addr_i, FERS_OFS_CTRL) && wr_data_i[FERS_BIT_CTRL_START];
   assign rd_istat  = rd_i && fers_hit(addr_i, FERS_OFS_IRQ_STAT);

   // check outcomes, shared by the flags and the abort decision
   logic chk_prot;
   logic chk_key;
   logic chk_blk;
   logic chk_boot;
   logic chk_any;

   assign chk_prot = flash_error_state_i;
   assign chk_key  = flash_key_reg_i != FERS_KEY_GOOD;
   assign chk_blk  = eblk_q > LAST_BLOCK;
   assign chk_boot = array_select_reg_i == FERS_SEL_USR_BOOT;
   // the boot select is left out here: it is judged only after the others
   assign chk_any  = chk_prot | chk_key | chk_blk;

   // completion outcome in the wait state
   logic wait_end;
   logic exec_bad;

   // a timeout ends the wait just like a done from the array engine
   assign wait_end = erase_done_i || (tmo_q == TMO_LAST);
   // a settings change in the last wait cycle still counts as a fault
   assign exec_bad = erase_fail_i | chg_q | settings_changed_i | !erase_done_i;

   // erase sequencer: check, launch, wait, then publish the result word
   always_comb begin
      state_d  = state_q;
      result_d = result_q;
      prot_d   = prot_q;
      key_d    = key_q;
      blk_d    = blk_q;
      chg_d    = chg_q;
      tmo_d    = tmo_q;
      start_d  = 1'b0;
      eblk_d   = eblk_q;
      ev_done  = 1'b0;
      ev_fail  = 1'b0;
      case (state_q)
         FERS_IDLE: begin
            // a start while busy is ignored rather than queued
            if (start_req) begin
               state_d = FERS_CHECK;
               eblk_d  = block_num_i;
            end
         end
         FERS_CHECK: begin
            // all checks sample the settings before anything is erased
            prot_d = chk_prot;
            key_d  = chk_key;
            blk_d  = chk_blk;
            // fresh change tracker and watchdog for this attempt
            chg_d  = 1'b0;
            tmo_d  = 24'h000000;
            if (chk_any) begin
               // protect, key or block fault: abort with the matching flags
               result_d = fers_pack(chk_prot, 1'b0, chk_key, chk_blk);
               ev_done  = 1'b1;
               ev_fail  = 1'b1;
               state_d  = FERS_IDLE;
            end else if (chk_boot) begin
               // boot array selected: refuse, neither array is touched
               result_d = fers_pack(1'b0, 1'b1, 1'b0, 1'b0);
               ev_done  = 1'b1;
               ev_fail  = 1'b1;
               state_d  = FERS_IDLE;
            end else begin
               // all checks clean: one launch pulse to the array engine
               start_d = 1'b1;
               state_d = FERS_RUN;
            end
         end
         FERS_RUN: begin
            // one cycle after launch before completion is looked at
            chg_d   = chg_q | settings_changed_i;
            state_d = FERS_WAIT;
         end
         FERS_WAIT: begin
            // settings changes stay remembered until the result is out
            chg_d = chg_q | settings_changed_i;
            tmo_d = tmo_q + 24'h000001;
            if (wait_end) begin
               // timeout counts as an array that could not be erased
               result_d = fers_pack(prot_q | flash_error_state_i, exec_bad,
                                    key_q, blk_q);
               ev_done  = 1'b1;
               ev_fail  = flash_error_state_i | exec_bad;
               state_d  = FERS_IDLE;
            end
         end
         default: begin
            state_d = FERS_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q  <= FERS_IDLE;
         result_q <= FERS_RST_RESULT;
         prot_q   <= 1'b0;
         key_q    <= 1'b0;
         blk_q    <= 1'b0;
         chg_q    <= 1'b0;
         tmo_q    <= 24'h000000;
         start_q  <= 1'b0;
         eblk_q   <= '0;
      end else begin
         state_q  <= state_d;
         result_q <= result_d;
         prot_q   <= prot_d;
         key_q    <= key_d;
         blk_q    <= blk_d;
         chg_q    <= chg_d;
         tmo_q    <= tmo_d;
         start_q  <= start_d;
         eblk_q   <= eblk_d;
      end
   end

   // interrupt status: events set, read clears, set wins over clear
   always_comb begin
      istat_d = rd_istat ? 2'h0 : istat_q;
      if (ev_done)
         istat_d[FERS_BIT_IRQ_DONE] = 1'b1;
      if (ev_fail)
         istat_d[FERS_BIT_IRQ_FAIL] = 1'b1;
      imask_d = imask_q;
      if (wr_i && fers_hit(addr_i, FERS_OFS_IRQ_MASK))
         imask_d = wr_data_i[1:0];
      irq_d = |(istat_d & imask_d);
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         istat_q <= 2'h0;
         imask_q <= FERS_RST_IRQ_MASK;
         irq_q   <= 1'b0;
      end else begin
         istat_q <= istat_d;
         imask_q <= imask_d;
         irq_q   <= irq_d;
      end
   end

   // read data stand only in the cycle after the strobe; unmapped reads zero
   always_comb begin
      rdata_d = 8'h00;
      if (rd_i) begin
         case (addr_i)
            FERS_OFS_RESULT:   rdata_d = result_q;
            FERS_OFS_STATUS:   rdata_d = {7'h00, state_q != FERS_IDLE};
            FERS_OFS_IRQ_STAT: rdata_d = {6'h00, istat_q};
            FERS_OFS_IRQ_MASK: rdata_d = {6'h00, imask_q};
            default:           rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // outputs straight from flops
   assign rd_data_o     = rdata_q;
   assign erase_start_o = start_q;
   assign erase_block_o = eblk_q;
   assign irq_o         = irq_q;

endmodule : fers_top

// *** testbench/fers_properties.sv ***
// concurrent checks on the erase result sequencer ports
`timescale 1ns/1ps
module fers_properties
   import fers_pkg::*;
#(
   parameter int BLK_W      = 4,
   parameter int NUM_BLOCKS = 8
) (
   input wire logic             sys_clk_i,
   input wire logic             reset_i,
   input wire logic [7:0]       addr_i,
   input wire logic [7:0]       wr_data_i,
   input wire logic             wr_i,
   input wire logic             rd_i,
   input wire logic [7:0]       flash_key_reg_i,
   input wire logic [7:0]       array_select_reg_i,
   input wire logic [BLK_W-1:0] block_num_i,
   input wire logic             flash_error_state_i,
   input wire logic [7:0]       rd_data_o,
   input wire logic             erase_start_o,
   input wire logic [BLK_W-1:0] erase_block_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // start write alone; the abort checks look at key, select, protect one cycle later
   sequence s_go;
      wr_i && addr_i == FERS_OFS_CTRL && wr_data_i[0];
   endsequence
   sequence s_rd;
      rd_i && addr_i == FERS_OFS_RESULT;
   endsequence
   unused_bits_a: assert property (s_rd |=> rd_data_o[7] == 1'b0 &&
      rd_data_o[2:1] == 2'h0) else $error("unused result bits set");
   fail_sum_a: assert property (s_rd |=> rd_data_o[0] == (|rd_data_o[6:3]))
      else $error("pass fail bit disagrees with error flags");
   key_abort_a: assert property (s_go ##1 flash_key_reg_i != FERS_KEY_GOOD
      |=> !erase_start_o) else $error("erase launched with bad key");
   prot_abort_a: assert property (s_go ##1 flash_error_state_i
      |=> !erase_start_o) else $error("erase launched in protect state");
   boot_abort_a: assert property (s_go ##1 array_select_reg_i == FERS_SEL_USR_BOOT
      |=> !erase_start_o) else $error("erase launched on boot array");
   blk_abort_a: assert property ((s_go and int'(block_num_i) >= NUM_BLOCKS)
      |-> ##2 !erase_start_o) else $error("erase launched on bad block");
   start_guard_a: assert property (erase_start_o |->
      $past(flash_key_reg_i) == FERS_KEY_GOOD && !$past(flash_error_state_i)
      && $past(array_select_reg_i) != FERS_SEL_USR_BOOT) else $error("unchecked launch");
   start_blk_a: assert property (erase_start_o |-> int'(erase_block_o) < NUM_BLOCKS)
      else $error("launch block out of range");
endmodule : fers_properties

bind fers_top fers_properties #(.BLK_W(BLK_W), .NUM_BLOCKS(NUM_BLOCKS)) u_fers_properties (
   .sys_clk_i, .reset_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .flash_key_reg_i,
   .array_select_reg_i, .block_num_i, .flash_error_state_i, .rd_data_o,
   .erase_start_o, .erase_block_o);

// *** testbench/fers_top_bench.sv ***
// self-checking bench for the erase result sequencer
`timescale 1ns/1ps
module fers_top_bench;
   import fers_pkg::*;
   typedef struct packed {
      logic [7:0] key;
      logic [7:0] sel;
      logic [3:0] blk;
      logic [3:0] ctl; // protect, changed, done, fail
      logic [7:0] res;
   } fers_row_t;
   logic       clk, rst, wr, rd, prot, chg, done, efail, est, irq;
   logic [7:0] addr, wd, key, sel, rdata, v;
   logic [3:0] blk, eblk;
   int         fails, num_checks, i;
   // one row per erase outcome; blk 8 sits just past the last block
   fers_row_t  rows [8] = '{'{8'h5a, 8'h00, 4'h7, 4'b0010, 8'h00},
      '{8'h5b, 8'h00, 4'h0, 4'b0010, 8'h11}, '{8'h5a, 8'h00, 4'h0, 4'b1010, 8'h41},
      '{8'h5a, 8'h00, 4'h8, 4'b0010, 8'h09}, '{8'h5a, 8'haa, 4'h0, 4'b0010, 8'h21},
      '{8'h5a, 8'h00, 4'h1, 4'b0011, 8'h21}, '{8'h5a, 8'h00, 4'h2, 4'b0110, 8'h21},
      '{8'h5a, 8'h00, 4'h3, 4'b0000, 8'h21}};

   fers_top #(.TIMEOUT_CYCLES(20)) u_fers_top (.sys_clk_i(clk), .reset_i(rst),
      .addr_i(addr), .wr_data_i(wd), .wr_i(wr), .rd_i(rd), .flash_key_reg_i(key),
      .array_select_reg_i(sel), .block_num_i(blk), .flash_error_state_i(prot),
      .settings_changed_i(chg), .erase_done_i(done), .erase_fail_i(efail),
      .rd_data_o(rdata), .erase_start_o(est), .erase_block_o(eblk), .irq_o(irq));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr8
   // read data stand only in the cycle after the strobe
   task automatic rd8(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd8
   // bounded poll on busy so a stuck sequencer cannot hang the run
   task automatic run(input fers_row_t r);
      int n;
      @(posedge clk);
      key <= r.key;
      sel <= r.sel;
      blk <= r.blk;
      {prot, chg, done, efail} <= r.ctl;
      wr8(FERS_OFS_CTRL, 8'h01);
      rd8(FERS_OFS_STATUS);
      if (r.ctl[1] === 1'b0) chk(v & 8'h01, 8'h01, "busy");
      for (n = 0; n < 40 && v[0] !== 1'b0; n++) rd8(FERS_OFS_STATUS);
      chk(v & 8'h01, 8'h00, "idle");
   endtask : run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #400000 fails++;
      complete_run();
   end
   initial begin
      {rst, wr, rd, prot, chg, done, efail} = 7'h40;
      {addr, wd, key, sel, blk} = 36'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd8(FERS_OFS_RESULT);
      chk(v, FERS_RST_RESULT, "reset result");
      rd8(8'h20);
      chk(v, 8'h00, "unmapped");
      wr8(FERS_OFS_IRQ_MASK, 8'h03);
      for (i = 0; i < 8; i++) begin
         run(rows[i]);
         rd8(FERS_OFS_RESULT);
         chk(v, rows[i].res, "result");
         if (rows[i].res === 8'h00) chk({4'h0, eblk}, {4'h0, rows[i].blk}, "block");
         chk({7'h0, irq}, 8'h01, "irq");
         rd8(FERS_OFS_IRQ_STAT);
         chk({7'h0, v[FERS_BIT_IRQ_FAIL]}, {7'h0, rows[i].res[0]}, "fail event");
         $display("row %0d finished", i);
      end
      // fault removed after an execution error, the array is erased again
      run(rows[0]);
      rd8(FERS_OFS_RESULT);
      chk(v, 8'h00, "re-erase");
      $display("re-erase test finished");
      // masked out, a failing erase must leave the interrupt low
      wr8(FERS_OFS_IRQ_MASK, 8'h00);
      rd8(FERS_OFS_IRQ_MASK);
      chk(v, 8'h00, "mask");
      run(rows[1]);
      chk({7'h0, irq}, 8'h00, "masked irq");
      $display("mask test finished");
      // second reset while idle, after the masked run, clears the result word
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd8(FERS_OFS_RESULT);
      chk(v, FERS_RST_RESULT, "reset again");
      $display("reset test finished");
      complete_run();
   end
endmodule : fers_top_bench
